// ---- verilog/cmb_ctrl.sv ----
/*
  Message buffer control: paired transmit control registers, message RAM
  reached by DMA, transmit selection and frame word streaming.
  Assumes a protocol engine on the same clock that drains frame words,
  reports the outcome of the frame in flight and writes received messages.
*/
// Overview of operation
// - Control registers exist for pairs 0/1..6/7; upper byte odd, lower even.
// - Direction bit one makes buffer transmit, zero makes it receive.
// - Abort sets abort flag; successful completion leaves it zero.
// - Lost arbitration sets the arbitration-lost flag.
// - Bus error during this buffer's sending sets its error flag.
// - Writing one requests sending; hardware clears it after success.
// - Writing zero while request set aborts the pending transmission.
// - Setting send request clears the three status flags.
// - Remote frame with auto reply enabled sets send request.
// - Priority field: 11 highest down to 00 lowest.
// - Identifier, length, data and status words live in DMA RAM.
// - Word 0 holds standard id at 12..2; bits 15..13 read zero.
// - Word 0 bit 1 is the substitute remote request bit.
// - Word 0 bit 0 selects extended identifier.
// - Word 2 bit 9 is the remote transmission request bit.
// - Each of 32 buffers has eight payload bytes 0..7.
// - Payload packs two bytes per word, even byte low.
// - Received message sets buffer full flag; software clears it.
`timescale 1ns/10ps
`default_nettype none
`include "cmb_defines.svh"
module cmb_ctrl (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic sfr_wr_in,
  input wire logic [2:0] sfr_addr_in,
  input wire logic [15:0] sfr_wdata_in,
  output logic [15:0] sfr_rdata_out,
  input wire logic dma_wr_in,
  input wire logic [7:0] dma_addr_in,
  input wire logic [15:0] dma_wdata_in,
  output logic [15:0] dma_rdata_out,
  output logic frm_valid_out,
  input wire logic frm_ready_in,
  output logic [15:0] frm_data_out,
  output logic tx_active_out,
  output logic [2:0] tx_buf_out,
  output logic eng_abort_out,
  input wire logic eng_done_in,
  input wire logic eng_arb_lost_in,
  input wire logic eng_bus_err_in,
  input wire logic rx_wr_in,
  input wire logic [4:0] rx_buf_in,
  input wire logic [2:0] rx_word_in,
  input wire logic [15:0] rx_data_in,
  input wire logic rx_commit_in,
  input wire logic rx_remote_in
);
  logic [15:0] msg_ram [0:`CMB_RAM_WORDS-1];
  logic [7:0] ctl [0:`CMB_TX_BUFS-1];
  logic [7:0] next_ctl [0:`CMB_TX_BUFS-1];
  logic [31:0] rx_full, next_rx_full;
  cmb_pkg::cmb_state_type state, next_state;
  logic [2:0] cur, next_cur, word, next_word;
  logic next_abort;
  logic [15:0] next_dma_rdata, next_sfr_rdata;
  logic pick_valid, push, fifo_ready;
  logic [2:0] pick;

  // implemented bits of each message buffer word
  function automatic logic [15:0] word_mask(input logic [2:0] w);
    case (w)
      `CMB_W_SID: word_mask = `CMB_MASK_SID;
      `CMB_W_EID: word_mask = `CMB_MASK_EID;
      `CMB_W_DLC: word_mask = `CMB_MASK_DLC;
      `CMB_W_STAT: word_mask = `CMB_MASK_STAT;
      default: word_mask = `CMB_MASK_DATA;
    endcase
  endfunction

  // highest priority pending transmit buffer, lowest number on a tie
  always_comb
  begin
    pick_valid = 1'b0;
    pick = 3'h0;
    for (int i = 0; i < `CMB_TX_BUFS; i++)
    begin
      if (ctl[i][`CMB_F_DIR] && ctl[i][`CMB_F_REQ])
      begin
        if (!pick_valid || (ctl[i][1:0] > ctl[pick][1:0]))
        begin
          pick_valid = 1'b1;
          pick = 3'(i);
        end
      end
    end
  end

  assign push = (state == cmb_pkg::CMB_LOAD);
  assign tx_active_out = (state != cmb_pkg::CMB_IDLE);

  // frame words for the engine; a full queue stalls loading
  cmb_fifo #(.WIDTH(16), .DEPTH(`CMB_FIFO_DEPTH), .AW(5)) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .in_data_in(msg_ram[{cur, word}]),
    .out_valid_out(frm_valid_out),
    .out_ready_in(frm_ready_in),
    .out_data_out(frm_data_out)
  );

  // control bytes and receive full flags
  always_comb
  begin
    logic [7:0] wb;
    logic [7:0] nb;
    wb = 8'h00;
    nb = 8'h00;
    for (int i = 0; i < `CMB_TX_BUFS; i++)
    begin
      nb = ctl[i];
      wb = i[0] ? sfr_wdata_in[15:8] : sfr_wdata_in[7:0];
      if (sfr_wr_in && (sfr_addr_in == 3'(i >> 1)))
      begin
        nb[`CMB_F_DIR] = wb[`CMB_F_DIR];
        nb[`CMB_F_AUTO_REMOTE_REPLY_ENABLE] = wb[`CMB_F_AUTO_REMOTE_REPLY_ENABLE];
        nb[1:0] = wb[1:0];
        if (wb[`CMB_F_REQ] && !ctl[i][`CMB_F_REQ])
          nb[`CMB_F_ABT:`CMB_F_REQ] = 4'h1;
        else if (!wb[`CMB_F_REQ] && ctl[i][`CMB_F_REQ])
          nb[`CMB_F_ABT:`CMB_F_REQ] = {1'b1, 1'b0, ctl[i][`CMB_F_ERR], 1'b0};
      end
      if ((state == cmb_pkg::CMB_WAIT) && (cur == 3'(i)))
      begin
        if (eng_done_in)
        begin
          nb[`CMB_F_REQ] = 1'b0;
          nb[`CMB_F_ABT] = 1'b0;
        end
        if (eng_arb_lost_in)
          nb[`CMB_F_LARB] = 1'b1;
        if (eng_bus_err_in)
          nb[`CMB_F_ERR] = 1'b1;
      end
      if (rx_remote_in && (rx_buf_in == 5'(i)) && ctl[i][`CMB_F_DIR] &&
          ctl[i][`CMB_F_AUTO_REMOTE_REPLY_ENABLE] && !nb[`CMB_F_REQ])
        nb[`CMB_F_ABT:`CMB_F_REQ] = 4'h1;
      next_ctl[i] = nb;
    end
    next_rx_full = rx_full;
    if (sfr_wr_in && (sfr_addr_in == `CMB_RXFULL_LO_IDX))
      next_rx_full[15:0] = rx_full[15:0] & sfr_wdata_in;
    if (sfr_wr_in && (sfr_addr_in == `CMB_RXFULL_HI_IDX))
      next_rx_full[31:16] = rx_full[31:16] & sfr_wdata_in;
    if (rx_commit_in)
      next_rx_full[rx_buf_in] = 1'b1;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < `CMB_TX_BUFS; i++)
        ctl[i] <= `CMB_CTL_RESET;
      rx_full <= 32'h0000_0000;
    end
    else
    begin
      for (int i = 0; i < `CMB_TX_BUFS; i++)
        ctl[i] <= next_ctl[i];
      rx_full <= next_rx_full;
    end
  end

  // transmit sequencing
  always_comb
  begin
    next_state = state;
    next_cur = cur;
    next_word = word;
    next_abort = 1'b0;
    case (state)
      cmb_pkg::CMB_IDLE:
      begin
        if (pick_valid)
        begin
          next_cur = pick;
          next_word = 3'h0;
          next_state = cmb_pkg::CMB_LOAD;
        end
      end
      cmb_pkg::CMB_LOAD:
      begin
        if (fifo_ready)
        begin
          next_word = word + 3'h1;
          if (word == `CMB_FRAME_LAST)
          begin
            next_word = 3'h0;
            if (next_ctl[cur][`CMB_F_REQ])
              next_state = cmb_pkg::CMB_WAIT;
            else
            begin
              next_abort = 1'b1;
              next_state = cmb_pkg::CMB_IDLE;
            end
          end
        end
      end
      cmb_pkg::CMB_WAIT:
      begin
        if (eng_done_in || eng_arb_lost_in || eng_bus_err_in)
          next_state = cmb_pkg::CMB_IDLE;
        else if (!next_ctl[cur][`CMB_F_REQ])
        begin
          next_abort = 1'b1;
          next_state = cmb_pkg::CMB_IDLE;
        end
      end
      default: next_state = cmb_pkg::CMB_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= cmb_pkg::CMB_IDLE;
      cur <= 3'h0;
      word <= 3'h0;
      eng_abort_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cur <= next_cur;
      word <= next_word;
      eng_abort_out <= next_abort;
    end
  end

  assign tx_buf_out = cur;

  // register read data
  always_comb
  begin
    next_dma_rdata = msg_ram[dma_addr_in] & word_mask(dma_addr_in[2:0]);
    case (sfr_addr_in)
      `CMB_CTL_PAIR01_IDX: next_sfr_rdata = {ctl[1], ctl[0]};
      `CMB_CTL_PAIR23_IDX: next_sfr_rdata = {ctl[3], ctl[2]};
      `CMB_CTL_PAIR45_IDX: next_sfr_rdata = {ctl[5], ctl[4]};
      `CMB_CTL_PAIR67_IDX: next_sfr_rdata = {ctl[7], ctl[6]};
      `CMB_RXFULL_LO_IDX: next_sfr_rdata = rx_full[15:0];
      `CMB_RXFULL_HI_IDX: next_sfr_rdata = rx_full[31:16];
      default: next_sfr_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      dma_rdata_out <= 16'h0000;
      sfr_rdata_out <= 16'h0000;
    end
    else
    begin
      dma_rdata_out <= next_dma_rdata;
      sfr_rdata_out <= next_sfr_rdata;
    end
  end

  // message RAM; an engine write wins over a DMA write to the same word
  always_ff @(posedge sys_clk_in)
  begin
    if (dma_wr_in)
      msg_ram[dma_addr_in] <= dma_wdata_in & word_mask(dma_addr_in[2:0]);
    if (rx_wr_in)
      msg_ram[{rx_buf_in, rx_word_in}] <= rx_data_in & word_mask(rx_word_in);
  end

  AST_REQ_CLEARS_FLAGS: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    $rose(ctl[2][`CMB_F_REQ]) |-> (ctl[2][6:4] == 3'h0))
    else $error("flags not cleared when send request set");

  AST_DONE_CLEARS_REQ: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (state == cmb_pkg::CMB_WAIT) && eng_done_in && (cur == 3'h0) |=>
      !ctl[0][`CMB_F_REQ] && !ctl[0][`CMB_F_ABT] && (state == cmb_pkg::CMB_IDLE))
    else $error("send request not cleared after success");

  AST_ABORT_WRITE: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    sfr_wr_in && (sfr_addr_in == 3'h1) && !sfr_wdata_in[`CMB_F_REQ] && ctl[2][`CMB_F_REQ] &&
    !rx_remote_in && !((state == cmb_pkg::CMB_WAIT) && (cur == 3'h2) && eng_done_in) |=>
      ctl[2][`CMB_F_ABT] && !ctl[2][`CMB_F_REQ])
    else $error("abort write did not abort");

  AST_ARB_LOST: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (state == cmb_pkg::CMB_WAIT) && eng_arb_lost_in && !eng_done_in && (cur == 3'h2) &&
    !sfr_wr_in |=> (ctl[2][`CMB_F_LARB] && (state == cmb_pkg::CMB_IDLE))
      ##1 (state == cmb_pkg::CMB_LOAD))
    else $error("arbitration loss not recorded");

  AST_BUS_ERR: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (state == cmb_pkg::CMB_WAIT) && eng_bus_err_in && !sfr_wr_in |=>
      ctl[$past(cur)][`CMB_F_ERR])
    else $error("bus error not recorded");

  AST_AUTO_REPLY: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    rx_remote_in && (rx_buf_in == 5'h03) && ctl[3][`CMB_F_DIR] && ctl[3][`CMB_F_AUTO_REMOTE_REPLY_ENABLE] |=>
      ctl[3][`CMB_F_REQ])
    else $error("remote frame did not set send request");

  AST_NO_AUTO_REPLY: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    rx_remote_in && (rx_buf_in == 5'h02) && !ctl[2][`CMB_F_AUTO_REMOTE_REPLY_ENABLE] && !ctl[2][`CMB_F_REQ] &&
    !sfr_wr_in |=> !ctl[2][`CMB_F_REQ])
    else $error("send request set without auto reply");

  AST_RX_FULL: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    rx_commit_in |=> rx_full[$past(rx_buf_in)])
    else $error("buffer full flag not set");

  AST_SID_HIGH_ZERO: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !dma_wr_in && !rx_wr_in && (dma_addr_in[2:0] == `CMB_W_SID) |=> (dma_rdata_out[15:13] == 3'h0))
    else $error("identifier word upper bits not zero");

  AST_PICK_START: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (state == cmb_pkg::CMB_IDLE) && pick_valid |=>
      (state == cmb_pkg::CMB_LOAD) && (cur == $past(pick)) && (word == 3'h0))
    else $error("selected buffer not loaded");
endmodule
`default_nettype wire

// ---- verilog/cmb_defines.svh ----
/*
  Register indices, field positions, reset values and word masks for the
  message buffer control block.
  Assumes it is included by bare name from design files under verilog/.
*/
`ifndef CMB_DEFINES_SVH
`define CMB_DEFINES_SVH

// control and receive full register indices on the special function register port
`define CMB_CTL_PAIR01_IDX 3'h0
`define CMB_CTL_PAIR23_IDX 3'h1
`define CMB_CTL_PAIR45_IDX 3'h2
`define CMB_CTL_PAIR67_IDX 3'h3
`define CMB_RXFULL_LO_IDX 3'h4
`define CMB_RXFULL_HI_IDX 3'h5

// per-buffer control byte fields
`define CMB_F_DIR 7
`define CMB_F_ABT 6
`define CMB_F_LARB 5
`define CMB_F_ERR 4
`define CMB_F_REQ 3
`define CMB_F_AUTO_REMOTE_REPLY_ENABLE 2
`define CMB_F_PRI_HI 1
`define CMB_F_PRI_LO 0
`define CMB_CTL_RESET 8'h00

// message buffer word indices and implemented-bit masks
`define CMB_W_SID 3'h0
`define CMB_W_EID 3'h1
`define CMB_W_DLC 3'h2
`define CMB_W_STAT 3'h7
`define CMB_MASK_SID 16'h1fff
`define CMB_MASK_EID 16'h0fff
`define CMB_MASK_DLC 16'hff1f
`define CMB_MASK_DATA 16'hffff
`define CMB_MASK_STAT 16'h1f00
`define CMB_FRAME_LAST 3'h6

`define CMB_TX_BUFS 8
`define CMB_RAM_WORDS 256
`define CMB_FIFO_DEPTH 32

`endif

// ---- verilog/cmb_pkg.sv ----
/*
  Types shared by the message buffer control block.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package cmb_pkg;
  typedef enum logic [1:0] {
    CMB_IDLE = 2'h0,
    CMB_LOAD = 2'h1,
    CMB_WAIT = 2'h3
  } cmb_state_type;
endpackage
`default_nettype wire

// ---- verilog/cmb_fifo.sv ----
/*
  Synchronous FIFO with valid/ready on both sides and registered output data.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module cmb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [WIDTH-1:0] next_out_data;
  logic full, empty, push, pop;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign push = in_valid_in && !full;
  assign pop = out_ready_in && !empty;

  always_comb
  begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    // head word shown from a flop; a push into an empty queue is forwarded
    if (next_wr_ptr == next_rd_ptr)
      next_out_data = out_data_out;
    else if (push && (wr_ptr[AW-1:0] == next_rd_ptr[AW-1:0]))
      next_out_data = in_data_in;
    else
      next_out_data = store[next_rd_ptr[AW-1:0]];
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      out_data_out <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      out_data_out <= next_out_data;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (push)
      store[wr_ptr[AW-1:0]] <= in_data_in;
  end
endmodule
`default_nettype wire

// ---- tb/cmb_eng_model.sv ----
/*
  Behavioural protocol engine: drains frame words, reports frame outcomes.
  Assumes the control block's clock and active-low asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module cmb_eng_model (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic frm_valid_in,
  input wire logic [15:0] frm_data_in,
  input wire logic slow_in,
  output logic frm_ready_out,
  output logic eng_done_out,
  output logic eng_arb_lost_out,
  output logic eng_bus_err_out
);
  logic [15:0] words [0:6];
  int count;
  logic tick;
  initial
  begin
    eng_done_out = 1'b0;
    eng_arb_lost_out = 1'b0;
    eng_bus_err_out = 1'b0;
  end
  // slow mode takes a word only every other cycle
  assign frm_ready_out = !slow_in || tick;
  always @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      count <= 0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= !tick;
      if (frm_valid_in && frm_ready_out)
      begin
        if (count < 7)
          words[count] <= frm_data_in;
        count <= count + 1;
      end
    end
  end
  task automatic clear();
    @(posedge sys_clk_in);
    count <= 0;
  endtask
  // kind 0 done, 1 arbitration lost, 2 bus error; one-cycle pulse
  task automatic report(input int kind);
    @(posedge sys_clk_in);
    #1;
    eng_done_out = (kind == 0);
    eng_arb_lost_out = (kind == 1);
    eng_bus_err_out = (kind == 2);
    @(posedge sys_clk_in);
    #1;
    eng_done_out = 1'b0;
    eng_arb_lost_out = 1'b0;
    eng_bus_err_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_can_message_buffer_tx_control.sv ----
/*
  Self-checking bench for the message buffer control block.
  Assumes the engine model in cmb_eng_model.sv on the frame port.
*/
`timescale 1ns/10ps
`default_nettype none
module test_can_message_buffer_tx_control;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic sfr_wr_in = 1'b0;
  logic dma_wr_in = 1'b0;
  logic rx_wr_in = 1'b0;
  logic rx_commit_in = 1'b0;
  logic rx_remote_in = 1'b0;
  logic slow = 1'b0;
  logic [2:0] sfr_addr_in = 3'h0;
  logic [2:0] rx_word_in = 3'h0;
  logic [4:0] rx_buf_in = 5'h00;
  logic [7:0] dma_addr_in = 8'h00;
  logic [15:0] sfr_wdata_in = 16'h0000;
  logic [15:0] dma_wdata_in = 16'h0000;
  logic [15:0] rx_data_in = 16'h0000;
  logic [15:0] sfr_rdata_out, dma_rdata_out, frm_data_out, rd;
  logic [2:0] tx_buf_out;
  logic frm_valid_out, frm_ready_in, tx_active_out, eng_abort_out;
  logic eng_done_in, eng_arb_lost_in, eng_bus_err_in;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int aborts = 0;
  cmb_ctrl dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .sfr_wr_in(sfr_wr_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .dma_wr_in(dma_wr_in), .dma_addr_in(dma_addr_in), .dma_wdata_in(dma_wdata_in),
    .dma_rdata_out(dma_rdata_out), .frm_valid_out(frm_valid_out), .frm_ready_in(frm_ready_in),
    .frm_data_out(frm_data_out), .tx_active_out(tx_active_out), .tx_buf_out(tx_buf_out),
    .eng_abort_out(eng_abort_out), .eng_done_in(eng_done_in),
    .eng_arb_lost_in(eng_arb_lost_in), .eng_bus_err_in(eng_bus_err_in), .rx_wr_in(rx_wr_in),
    .rx_buf_in(rx_buf_in), .rx_word_in(rx_word_in), .rx_data_in(rx_data_in),
    .rx_commit_in(rx_commit_in), .rx_remote_in(rx_remote_in));
  cmb_eng_model eng (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .frm_valid_in(frm_valid_out),
    .frm_data_in(frm_data_out), .slow_in(slow), .frm_ready_out(frm_ready_in),
    .eng_done_out(eng_done_in), .eng_arb_lost_out(eng_arb_lost_in),
    .eng_bus_err_out(eng_bus_err_in));
  always #4 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (eng_abort_out === 1'b1)
      aborts++;
    if (cycles == 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  task automatic conclude();
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic sfr_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    #1;
    sfr_wr_in = 1'b1;
    sfr_addr_in = a;
    sfr_wdata_in = d;
    @(posedge sys_clk_in);
    #1;
    sfr_wr_in = 1'b0;
  endtask
  task automatic sfr_rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge sys_clk_in);
    #1;
    sfr_addr_in = a;
    @(posedge sys_clk_in);
    #1;
    d = sfr_rdata_out;
  endtask
  task automatic dma_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    #1;
    dma_wr_in = 1'b1;
    dma_addr_in = a;
    dma_wdata_in = d;
    @(posedge sys_clk_in);
    #1;
    dma_wr_in = 1'b0;
  endtask
  task automatic dma_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk_in);
    #1;
    dma_addr_in = a;
    @(posedge sys_clk_in);
    #1;
    d = dma_rdata_out;
  endtask
  function automatic logic [15:0] pat(input logic [4:0] b, input logic [2:0] w);
    pat = (16'ha5c3 ^ {w, b, 8'h00}) & ((w == 3'h2) ? 16'hfeef : 16'hffff);
  endfunction
  function automatic logic [15:0] msk(input logic [2:0] w, input logic [15:0] v);
    msk = (w == 3'h0) ? (v & 16'h1fff) : (w == 3'h1) ? (v & 16'h0fff) :
      (w == 3'h2) ? (v & 16'hff1f) : v;
  endfunction
  task automatic fill(input logic [4:0] b);
    for (int w = 0; w < 7; w++)
      dma_wr({b, 3'(w)}, pat(b, 3'(w)));
  endtask
  // wait for a whole frame, then compare buffer number and words
  task automatic take(input logic [4:0] b);
    int t;
    t = 0;
    while (eng.count < 7 && t < 200)
    begin
      @(posedge sys_clk_in);
      t++;
    end
    #1;
    check("tx_buf_out", {13'h0000, b[2:0]}, {13'h0000, tx_buf_out});
    for (int w = 0; w < 7; w++)
      check("frame word", msk(3'(w), pat(b, 3'(w))), eng.words[w]);
    eng.clear();
  endtask
  task automatic t_reset();
    for (int a = 0; a < 7; a++)
    begin
      sfr_rd(3'(a), rd);
      check("reset register", 16'h0000, rd);
    end
  endtask
  task automatic t_layout();
    dma_wr(8'h48, 16'hffff);
    dma_wr(8'h49, 16'hffff);
    dma_wr(8'h4a, 16'hfeef);
    dma_wr(8'h4f, 16'hffff);
    dma_wr(8'h4b, 16'h1234);
    dma_rd(8'h48, rd);
    check("id word", 16'h1fff, rd);
    dma_rd(8'h49, rd);
    check("ext id word", 16'h0fff, rd);
    dma_rd(8'h4a, rd);
    check("length word", 16'hfe0f, rd);
    dma_rd(8'h4f, rd);
    check("status word", 16'h1f00, rd);
    dma_rd(8'h4b, rd);
    check("payload word", 16'h1234, rd);
  endtask
  task automatic t_priority();
    fill(5'h00);
    fill(5'h01);
    sfr_wr(3'h0, 16'h8b89);
    take(5'h01);
    eng.report(0);
    take(5'h00);
    eng.report(0);
    sfr_rd(3'h0, rd);
    check("pair 0/1 control", 16'h8381, rd);
  endtask
  task automatic t_flags();
    slow = 1'b1;
    fill(5'h02);
    sfr_wr(3'h1, 16'h0088);
    take(5'h02);
    eng.report(1);
    sfr_rd(3'h1, rd);
    check("arbitration lost", 16'h00a8, rd);
    take(5'h02);
    eng.report(2);
    sfr_rd(3'h1, rd);
    check("bus error", 16'h0018, rd & 16'h0018);
    take(5'h02);
    aborts = 0;
    sfr_wr(3'h1, 16'h0080);
    repeat (4) @(posedge sys_clk_in);
    check("abort pulses", 16'h0001, 16'(aborts));
    sfr_rd(3'h1, rd);
    check("abort flag", 16'h00c0, rd & 16'h00c8);
    sfr_wr(3'h1, 16'h0088);
    sfr_rd(3'h1, rd);
    check("flags on request", 16'h0008, rd & 16'h0078);
    take(5'h02);
    eng.report(0);
    sfr_rd(3'h1, rd);
    check("after success", 16'h0080, rd);
    slow = 1'b0;
  endtask
  task automatic remote(input logic [4:0] b);
    @(posedge sys_clk_in);
    #1;
    rx_remote_in = 1'b1;
    rx_buf_in = b;
    @(posedge sys_clk_in);
    #1;
    rx_remote_in = 1'b0;
  endtask
  task automatic t_remote();
    fill(5'h03);
    sfr_wr(3'h1, 16'h8480);
    sfr_wr(3'h3, 16'h0008);
    remote(5'h02);
    repeat (12) @(posedge sys_clk_in);
    check("idle", 16'h0000, {15'h0000, tx_active_out});
    remote(5'h03);
    take(5'h03);
    eng.report(0);
  endtask
  // engine writes one received word, then commits the buffer
  task automatic rx_put(input logic [4:0] b, input logic [2:0] w, input logic [15:0] d);
    @(posedge sys_clk_in);
    #1;
    rx_wr_in = 1'b1;
    rx_buf_in = b;
    rx_word_in = w;
    rx_data_in = d;
    @(posedge sys_clk_in);
    #1;
    rx_wr_in = 1'b0;
    rx_commit_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    rx_commit_in = 1'b0;
  endtask
  task automatic t_receive();
    rx_put(5'h05, 3'h3, 16'hbeef);
    rx_put(5'h12, 3'h0, 16'hffff);
    sfr_rd(3'h4, rd);
    check("rx full", 16'h0020, rd);
    sfr_rd(3'h5, rd);
    check("rx full high", 16'h0004, rd);
    dma_rd(8'h2b, rd);
    check("received word", 16'hbeef, rd);
    dma_rd(8'h90, rd);
    check("received id word", 16'h1fff, rd);
    sfr_wr(3'h4, 16'h0000);
    sfr_rd(3'h4, rd);
    check("rx full cleared", 16'h0000, rd);
  endtask
  // reset again while a buffer is being loaded
  task automatic t_midreset();
    sfr_wr(3'h2, 16'h0088);
    @(posedge sys_clk_in);
    #1;
    rstn_in = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1;
    rstn_in = 1'b1;
    check("active after reset", 16'h0000, {15'h0000, tx_active_out});
    check("frame valid after reset", 16'h0000, {15'h0000, frm_valid_out});
    sfr_rd(3'h2, rd);
    check("pair 4/5 after reset", 16'h0000, rd);
    sfr_rd(3'h5, rd);
    check("rx full after reset", 16'h0000, rd);
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk_in);
    #1;
    rstn_in = 1'b1;
    t_reset();
    t_layout();
    t_priority();
    t_flags();
    t_remote();
    t_receive();
    t_midreset();
    conclude();
  end
endmodule
`default_nettype wire
